// >>> rtl/rdp_baud_gen.sv
// Baud divider: one-cycle pulse every half baud period
// Assumes i_clk is the crystal clock; restart realigns the phase
`timescale 1ns/1ps
`include "rdp_map.svh"
module rdp_baud_gen
  import rdp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_restart,
  input wire rdp_clk_cfg_t i_cfg,
  output logic [`RDP_CNT_W-1:0] o_half,
  output logic o_half_tick
);
  logic [`RDP_CNT_W-1:0] cnt_reg;
  logic [7:0] pre1_x2;
  always_comb begin
    case (i_cfg.pre1)
      3'h0: pre1_x2 = 8'h05;
      3'h1: pre1_x2 = 8'h06;
      3'h2: pre1_x2 = 8'h08;
      3'h3: pre1_x2 = 8'h0F;
      3'h4: pre1_x2 = 8'h19;
      3'h5: pre1_x2 = 8'h50;
      3'h6: pre1_x2 = 8'h60;
      default: pre1_x2 = 8'h80;
    endcase
  end
  // half period = 8/2 * (ref+1) * prescale_factor_first * prescale_factor_second
  always_comb begin
    o_half = `RDP_CNT_W'((`RDP_XOSC_DIV / 4) * ({1'b0, i_cfg.ref_div} + 4'h1) * pre1_x2)
             << i_cfg.pre2;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
    end else if (i_restart || cnt_reg >= o_half - `RDP_CNT_W'(1)) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + `RDP_CNT_W'(1);
    end
  end
  assign o_half_tick = !i_restart && cnt_reg >= o_half - `RDP_CNT_W'(1);
endmodule // rdp_baud_gen

// >>> rtl/rdp_bit_sync.sv
// Bit synchroniser: realigns on each input edge, samples mid-symbol
// Input is from logic on the same clock
`timescale 1ns/1ps
`include "rdp_map.svh"
module rdp_bit_sync (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_restart,
  input wire logic i_bit,
  input wire logic [`RDP_CNT_W-1:0] i_half,
  output logic o_bit,
  output logic o_strobe,
  output logic o_locked
);
  logic [`RDP_CNT_W-1:0] cnt_reg;
  logic prev_reg;
  logic edge_seen;
  assign edge_seen = i_bit != prev_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= i_bit;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
    end else if (i_restart || edge_seen || cnt_reg >= (i_half << 1) - `RDP_CNT_W'(1)) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + `RDP_CNT_W'(1);
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_locked <= 1'b0;
    end else if (i_restart) begin
      o_locked <= 1'b0;
    end else if (edge_seen) begin
      o_locked <= 1'b1;
    end
  end
  // Mid-symbol sample
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bit <= 1'b0;
      o_strobe <= 1'b0;
    end else begin
      o_strobe <= o_locked && !i_restart && cnt_reg == i_half - `RDP_CNT_W'(1);
      if (cnt_reg == i_half - `RDP_CNT_W'(1)) begin
        o_bit <= prev_reg;
      end
    end
  end
endmodule // rdp_bit_sync

// >>> rtl/rdp_data_port.sv
// Radio data port: line coding, bit sync and pin routing for the data side
// Avalon-MM register slave; host pins sampled through two flip-flops
//
// Summary of operation
// - Two-bit format field picks sync NRZ, async transparent or sync Manchester.
// - Sync NRZ transmit: device drives clock, samples host bit on rising edge.
// - Sync NRZ receive: device recovers timing, drives clock and data; host samples rising.
// - Async transmit modulates the data pin level directly, no sync or coding.
// - Async receive outputs raw demodulator data; host recovers timing itself.
// - Async, split clear: data pin carries both directions; clock pin shows format bit 0.
// - Async, split set: clock pin carries receive data; in transmit shows format bit 0.
// - Sync Manchester transmit: host gives NRZ bits on rising edge; device encodes.
// - Manchester carries one bit per two baud symbols: half the baud rate.
// - Sync Manchester receive: device syncs, decodes, presents NRZ with clock.
// - Zero is low-to-high, one is high-to-low, both encoding and decoding.
// - Sync modes keep the data clock running unless gating is enabled.
// - Sync with split set: lock pin outputs receive data in receive, inverted lock in transmit; else data pin bidirectional.
// - Baud is crystal over eight, reference divider plus one, and both prescalers.
// - Second prescaler codes 00..11 give factors 1, 2, 4, 8.
// - First prescaler codes give 2.5, 3, 4, 7.5, 12.5, 40, 48, 64.
// - Async mode passes any rate, ignoring divider settings.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
`include "rdp_map.svh"
module rdp_data_port
  import rdp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [`RDP_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_data_io_in,
  output logic o_data_io_out,
  output logic o_data_io_oe_n,
  output logic o_data_clock,
  output logic o_lock_pin,
  input wire logic i_demod_bit,
  input wire logic i_carrier_sense,
  input wire logic i_pll_lock,
  output logic o_mod_bit
);
  rdp_fmt_t fmt_reg;
  logic split_reg;
  logic gate_cs_reg;
  logic gate_lock_reg;
  rdp_clk_cfg_t clk_a_reg;
  rdp_clk_cfg_t clk_b_reg;
  logic tx_reg;
  logic fsel_reg;
  logic restart_reg;
  logic wait_reg;
  logic req;
  logic wr_en;
  logic din_meta_reg;
  logic din_sync_reg;
  logic [`RDP_CNT_W-1:0] half;
  logic half_tick;
  logic tick;
  logic clk_run;
  logic is_async;
  logic is_man;
  logic man_div_reg;
  logic toggle_now;
  logic rise;
  logic fall;
  logic data_clock_pin_reg;
  logic hold_bit_reg;
  logic mod_next;
  logic sym_bit;
  logic sym_strobe;
  logic sym_locked;
  logic first_sym_reg;
  logic dec_bit_reg;
  logic rx_out_reg;
  rdp_rx_state_t rx_state_reg;

  assign req = i_avs_read || i_avs_write;
  assign wr_en = i_avs_write && !wait_reg;
  assign is_async = fmt_reg[1];
  assign is_man = fmt_reg == RDP_FMT_MAN;

  // One wait cycle per access
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !(req && wait_reg);
    end
  end
  assign o_avs_waitrequest = wait_reg;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read && wait_reg) begin
      if (i_avs_address == `RDP_OFS_DEMOD) begin
        o_avs_readdata <= {30'h0, fmt_reg};
      end else if (i_avs_address == `RDP_OFS_IFACE) begin
        o_avs_readdata <= {29'h0, gate_lock_reg, gate_cs_reg, split_reg};
      end else if (i_avs_address == `RDP_OFS_CLK_A) begin
        o_avs_readdata <= {24'h0, clk_a_reg};
      end else if (i_avs_address == `RDP_OFS_CLK_B) begin
        o_avs_readdata <= {24'h0, clk_b_reg};
      end else if (i_avs_address == `RDP_OFS_MAIN) begin
        o_avs_readdata <= {30'h0, fsel_reg, tx_reg};
      end else if (i_avs_address == `RDP_OFS_STATUS) begin
        o_avs_readdata <= {26'h0, rx_out_reg, o_mod_bit, sym_locked, clk_run, rx_state_reg};
      end else begin
        o_avs_readdata <= '0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fmt_reg <= rdp_fmt_t'(`RDP_RST_FMT);
    end else if (wr_en && i_avs_address == `RDP_OFS_DEMOD) begin
      fmt_reg <= rdp_fmt_t'(i_avs_writedata[1:0]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      split_reg <= 1'b0;
      gate_cs_reg <= 1'b0;
      gate_lock_reg <= 1'b0;
    end else if (wr_en && i_avs_address == `RDP_OFS_IFACE) begin
      split_reg <= i_avs_writedata[`RDP_IF_SPLIT];
      gate_cs_reg <= i_avs_writedata[`RDP_IF_GATE_CS];
      gate_lock_reg <= i_avs_writedata[`RDP_IF_GATE_LOCK];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clk_a_reg <= rdp_clk_cfg_t'(`RDP_RST_CLK);
      clk_b_reg <= rdp_clk_cfg_t'(`RDP_RST_CLK);
    end else if (wr_en && i_avs_address == `RDP_OFS_CLK_A) begin
      clk_a_reg <= rdp_clk_cfg_t'(i_avs_writedata[7:0]);
    end else if (wr_en && i_avs_address == `RDP_OFS_CLK_B) begin
      clk_b_reg <= rdp_clk_cfg_t'(i_avs_writedata[7:0]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_reg <= 1'b0;
      fsel_reg <= 1'b0;
    end else if (wr_en && i_avs_address == `RDP_OFS_MAIN) begin
      tx_reg <= i_avs_writedata[`RDP_MAIN_TX];
      fsel_reg <= i_avs_writedata[`RDP_MAIN_FSEL];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      restart_reg <= 1'b1;
    end else begin
      restart_reg <= wr_en && i_avs_address != `RDP_OFS_STATUS &&
                     i_avs_address <= `RDP_OFS_MAIN && i_avs_address[1:0] == 2'h0;
    end
  end

  // Host data pin synchroniser
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      din_meta_reg <= 1'b0;
      din_sync_reg <= 1'b0;
    end else begin
      din_meta_reg <= i_data_io_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  // clock set follows frequency word select
  rdp_baud_gen u_baud (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_restart(restart_reg),
    .i_cfg(fsel_reg ? clk_b_reg : clk_a_reg),
    .o_half(half),
    .o_half_tick(half_tick)
  );

  // optional gating by carrier sense or lock
  assign clk_run = !(gate_cs_reg && !i_carrier_sense) && !(gate_lock_reg && !i_pll_lock);
  assign tick = half_tick && clk_run && !is_async;
  // Manchester clock at half the NRZ rate
  assign toggle_now = tick && (!is_man || man_div_reg);
  assign rise = toggle_now && !data_clock_pin_reg;
  assign fall = toggle_now && data_clock_pin_reg;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      man_div_reg <= 1'b0;
    end else if (restart_reg) begin
      man_div_reg <= 1'b0;
    end else if (tick) begin
      man_div_reg <= !man_div_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      data_clock_pin_reg <= 1'b0;
    end else if (restart_reg || is_async) begin
      data_clock_pin_reg <= 1'b0;
    end else if (toggle_now) begin
      data_clock_pin_reg <= !data_clock_pin_reg;
    end
  end

  // Transmit path
  always_comb begin
    mod_next = o_mod_bit;
    if (is_async) begin
      mod_next = din_sync_reg;
    end else if (rise) begin
      // sample on rising edge; zero starts low
      mod_next = din_sync_reg;
    end else if (fall && is_man) begin
      mod_next = !hold_bit_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mod_bit <= 1'b0;
      hold_bit_reg <= 1'b0;
    end else if (tx_reg) begin
      o_mod_bit <= mod_next;
      if (rise) begin
        hold_bit_reg <= din_sync_reg;
      end
    end
  end

  rdp_bit_sync u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_restart(restart_reg || tx_reg || is_async),
    .i_bit(i_demod_bit),
    .i_half(half),
    .o_bit(sym_bit),
    .o_strobe(sym_strobe),
    .o_locked(sym_locked)
  );

  // Manchester symbol pairing, slip on equal pair
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_state_reg <= RDP_RX_HUNT;
      first_sym_reg <= 1'b0;
      dec_bit_reg <= 1'b0;
    end else if (restart_reg || !is_man || !sym_locked) begin
      rx_state_reg <= RDP_RX_HUNT;
    end else if (sym_strobe) begin
      case (rx_state_reg)
        RDP_RX_HUNT, RDP_RX_FIRST: begin
          first_sym_reg <= sym_bit;
          rx_state_reg <= RDP_RX_SECOND;
        end
        RDP_RX_SECOND: begin
          if (sym_bit != first_sym_reg) begin
            dec_bit_reg <= first_sym_reg;
            rx_state_reg <= RDP_RX_FIRST;
          end else begin
            first_sym_reg <= sym_bit;
          end
        end
        default: rx_state_reg <= RDP_RX_HUNT;
      endcase
    end
  end

  // present data on falling edge for host rising-edge capture
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_out_reg <= 1'b0;
    end else if (is_async) begin
      rx_out_reg <= i_demod_bit;
    end else if (fall) begin
      rx_out_reg <= is_man ? dec_bit_reg : sym_bit;
    end
  end

  // Pin routing
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_data_clock <= 1'b0;
      o_data_io_out <= 1'b0;
      o_data_io_oe_n <= 1'b1;
      o_lock_pin <= 1'b1;
    end else begin
      if (is_async && split_reg && !tx_reg) begin
        o_data_clock <= rx_out_reg;
      end else if (is_async) begin
        // inactive clock pin at format bit 0
        o_data_clock <= fmt_reg[0];
      end else begin
        o_data_clock <= data_clock_pin_reg;
      end
      // data pin drives only in receive without split
      o_data_io_oe_n <= tx_reg || split_reg;
      o_data_io_out <= rx_out_reg;
      if (!is_async && split_reg && !tx_reg) begin
        // lock pin overridden with receive data
        o_lock_pin <= rx_out_reg;
      end else begin
        o_lock_pin <= !i_pll_lock;
      end
    end
  end
endmodule // rdp_data_port

// >>> rtl/rdp_map.svh
// Register offsets, field positions, reset values and timing counts
// Included by the design modules, the checker and the bench; guard only
`ifndef RDP_MAP_SVH
`define RDP_MAP_SVH
`define RDP_ADDR_W 5
`define RDP_OFS_DEMOD 5'h00
`define RDP_OFS_IFACE 5'h04
`define RDP_OFS_CLK_A 5'h08
`define RDP_OFS_CLK_B 5'h0C
`define RDP_OFS_MAIN 5'h10
`define RDP_OFS_STATUS 5'h14
`define RDP_IF_SPLIT 0
`define RDP_IF_GATE_CS 1
`define RDP_IF_GATE_LOCK 2
`define RDP_MAIN_TX 0
`define RDP_MAIN_FSEL 1
`define RDP_RST_FMT 2'h0
`define RDP_RST_CLK 8'h00
`define RDP_XOSC_DIV 8
`define RDP_CNT_W 17
`endif

// >>> rtl/rdp_pkg.sv
// Types shared by the data port modules
// Uses no macros from rdp_map.svh and does not include it
package rdp_pkg;
  typedef enum logic [1:0] {
    RDP_FMT_NRZ = 2'h0,
    RDP_FMT_MAN = 2'h1,
    RDP_FMT_ASYNC_LO = 2'h2,
    RDP_FMT_ASYNC_HI = 2'h3
  } rdp_fmt_t;
  typedef struct packed {
    logic [1:0] pre2;
    logic [2:0] pre1;
    logic [2:0] ref_div;
  } rdp_clk_cfg_t;
  typedef enum logic [1:0] {
    RDP_RX_HUNT = 2'h0,
    RDP_RX_FIRST = 2'h1,
    RDP_RX_SECOND = 2'h3
  } rdp_rx_state_t;
endpackage

// >>> verif/rdp_host_model.sv
// Host model on the data pins: sends random bits, captures received bits
// Pin level is resolved by the bench from the device output enable
`timescale 1ns/1ps
module rdp_host_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_data_clock_pin,
  input wire logic i_pin,
  input wire logic i_kick,
  output logic o_bit,
  output logic o_rx
);
  logic data_clock_pin_d;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      data_clock_pin_d <= 1'h0;
      o_bit <= 1'h0;
    end else begin
      data_clock_pin_d <= i_data_clock_pin;
      if (i_kick || (data_clock_pin_d && !i_data_clock_pin)) begin
        o_bit <= 1'($urandom);
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rx <= 1'h0;
    end else if (!data_clock_pin_d && i_data_clock_pin) begin
      o_rx <= i_pin;
    end
  end
endmodule // rdp_host_model

// >>> verif/rdp_port_sva.sv
// Checker for the data port pins and register bus
// Sees only the port pins; tracks register writes itself
`timescale 1ns/1ps
`include "rdp_map.svh"
module rdp_port_sva (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [`RDP_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  input wire logic i_data_io_in,
  input wire logic o_data_io_oe_n,
  input wire logic o_data_clock,
  input wire logic o_lock_pin,
  input wire logic i_pll_lock,
  input wire logic o_mod_bit
);
  logic [1:0] fmt_q;
  logic [1:0] main_q;
  logic [2:0] ifc_q;
  logic [7:0] clka_q;
  logic [7:0] clkb_q;
  logic [3:0] quiet;
  logic wr_done;
  logic clk0;
  assign wr_done = i_avs_write && !o_avs_waitrequest;
  // Default divider, no gating, settled config
  assign clk0 = (main_q[1] ? clkb_q : clka_q) == 8'h00 && ifc_q[2:1] == 2'h0 && quiet > 4'h3;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fmt_q <= 2'h0;
      main_q <= 2'h0;
      ifc_q <= 3'h0;
      clka_q <= 8'h00;
      clkb_q <= 8'h00;
    end else if (wr_done) begin
      case (i_avs_address)
        `RDP_OFS_DEMOD: fmt_q <= i_avs_writedata[1:0];
        `RDP_OFS_IFACE: ifc_q <= i_avs_writedata[2:0];
        `RDP_OFS_CLK_A: clka_q <= i_avs_writedata[7:0];
        `RDP_OFS_CLK_B: clkb_q <= i_avs_writedata[7:0];
        `RDP_OFS_MAIN: main_q <= i_avs_writedata[1:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      quiet <= 4'h0;
    end else if (wr_done) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence taken_s;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence answer_s;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  sequence high_ten_s;
    o_data_clock[*8] ##1 o_data_clock[*2] ##1 !o_data_clock;
  endsequence
  one_wait_a: assert property (taken_s |=> answer_s)
    else $error("bus answer not after one wait");
  async_idle_a: assert property (fmt_q[1] && !(ifc_q[0] && !main_q[0]) && quiet > 4'h3
    |-> o_data_clock == fmt_q[0]) else $error("async clock pin not at format level");
  async_pass_a: assert property (fmt_q[1] && main_q[0] && quiet > 4'h6 && $rose(i_data_io_in)
    |-> ##[1:4] o_mod_bit) else $error("async pin not passed to modulator");
  tx_input_a: assert property (main_q[0] && quiet > 4'h3 |-> o_data_io_oe_n)
    else $error("data pin driven in transmit");
  split_input_a: assert property (ifc_q[0] && quiet > 4'h3 |-> o_data_io_oe_n)
    else $error("data pin driven with split pins");
  lock_pass_a: assert property (!(!fmt_q[1] && ifc_q[0] && !main_q[0]) && quiet > 4'h3
    |-> o_lock_pin == !$past(i_pll_lock)) else $error("lock pin not inverted lock");
  nrz_half_a: assert property (disable iff (!i_rstn || i_avs_write)
    fmt_q == 2'h0 && clk0 && $rose(o_data_clock) |-> high_ten_s)
    else $error("default half period not ten cycles");
  man_pair_a: assert property (disable iff (!i_rstn || i_avs_write)
    fmt_q == 2'h1 && main_q[0] && clk0 && $rose(o_data_clock)
    |-> ##20 o_mod_bit != $past(o_mod_bit, 20)) else $error("symbol halves not inverse");
endmodule // rdp_port_sva
bind rdp_data_port rdp_port_sva chk (.i_clk, .i_rstn, .i_avs_address, .i_avs_read,
  .i_avs_write, .i_avs_writedata, .o_avs_waitrequest, .i_data_io_in, .o_data_io_oe_n,
  .o_data_clock, .o_lock_pin, .i_pll_lock, .o_mod_bit);

// >>> verif/testbench.sv
// Bench: registers, line formats, pin routing, gating and baud divider
// Host model on the data pins; checker bound from its own file
`timescale 1ns/1ps
`include "rdp_map.svh"
module testbench;
  logic i_clk, i_rstn, i_avs_read, i_avs_write, i_demod_bit, i_carrier_sense, i_pll_lock, kick;
  logic [`RDP_ADDR_W-1:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, exp_q[$];
  logic o_avs_waitrequest, o_data_io_out, o_data_io_oe_n, o_data_clock, o_lock_pin, o_mod_bit;
  logic host_bit, host_rx, data_clock_pin_d;
  logic [31:0] msk [5] = '{32'h3, 32'h7, 32'hFF, 32'hFF, 32'h3};
  int d1x2 [8] = '{5, 6, 8, 15, 25, 80, 96, 128};
  int err_total, compares, cyc, n;
  wire logic pin_lvl = o_data_io_oe_n ? host_bit : o_data_io_out;
  rdp_data_port dut (.i_clk, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_data_io_in(pin_lvl),
    .o_data_io_out, .o_data_io_oe_n, .o_data_clock, .o_lock_pin, .i_demod_bit,
    .i_carrier_sense, .i_pll_lock, .o_mod_bit);
  rdp_host_model host (.i_clk, .i_rstn, .i_data_clock_pin(o_data_clock), .i_pin(pin_lvl),
    .i_kick(kick), .o_bit(host_bit), .o_rx(host_rx));
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic stop_test();
    $display("Mismatches: %0d, comparisons: %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH at %0t: word %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH at %0t: pin %b, expected %b", $time, g, e);
    end
  endtask
  // Read results are compared in order as they appear
  always @(posedge i_clk) begin
    data_clock_pin_d <= o_data_clock;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      stop_test();
    end
    if (i_avs_read && o_avs_waitrequest === 1'h0 && exp_q.size() > 0) begin
      chk_word(o_avs_readdata, exp_q.pop_front());
    end
  end
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_read <= !wr;
    i_avs_write <= wr;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'h0);
    i_avs_read <= 1'h0;
    i_avs_write <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'h0, a, 32'h0);
  endtask
  task automatic cfg(input logic [1:0] f, input logic [2:0] ifc, input logic [1:0] m);
    bus(1'h1, `RDP_OFS_DEMOD, {30'h0, f});
    bus(1'h1, `RDP_OFS_IFACE, {29'h0, ifc});
    bus(1'h1, `RDP_OFS_MAIN, {30'h0, m});
    repeat (8) @(posedge i_clk);
  endtask
  task automatic wait_rise();
    do @(posedge i_clk); while (!(o_data_clock === 1'h1 && data_clock_pin_d === 1'h0));
  endtask
  task automatic toggles(output int t);
    t = 0;
    repeat (50) begin
      @(posedge i_clk);
      if (o_data_clock !== data_clock_pin_d) t++;
    end
  endtask
  initial begin
    logic [7:0] c;
    logic [31:0] v;
    int t;
    void'($urandom(76207));
    i_rstn = 1'h0;
    i_avs_read = 1'h0;
    i_avs_write = 1'h0;
    i_avs_address = 5'h00;
    i_avs_writedata = 32'h0;
    i_demod_bit = 1'h0;
    i_carrier_sense = 1'h0;
    i_pll_lock = 1'h1;
    kick = 1'h0;
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'h1;
    for (int a = 0; a < 5; a++) rd(5'(a * 4), 32'h0);
    rd(5'h18, 32'h0);
    rd(`RDP_OFS_STATUS, 32'h4);
    for (int a = 0; a < 5; a++) begin
      v = $urandom;
      bus(1'h1, 5'(a * 4), v);
      rd(5'(a * 4), v & msk[a]);
    end
    bus(1'h1, 5'h1C, 32'hFFFFFFFF);
    rd(5'h1C, 32'h0);
    bus(1'h1, `RDP_OFS_CLK_A, 32'h0);
    bus(1'h1, `RDP_OFS_CLK_B, 32'h0);
    for (int f = 2; f < 4; f++) begin
      cfg(2'(f), 3'h0, 2'h1);
      chk_pin(o_data_clock, f[0]);
      kick <= 1'h1;
      @(posedge i_clk);
      kick <= 1'h0;
      repeat (6) @(posedge i_clk);
      chk_pin(o_mod_bit, host_bit);
      cfg(2'(f), 3'h1, 2'h1);
      chk_pin(o_data_clock, f[0]);
      i_demod_bit <= 1'($urandom);
      cfg(2'(f), 3'h0, 2'h0);
      chk_pin(o_data_io_out, i_demod_bit);
      chk_pin(o_data_io_oe_n, 1'h0);
      cfg(2'(f), 3'h1, 2'h0);
      chk_pin(o_data_clock, i_demod_bit);
      chk_pin(o_lock_pin, !i_pll_lock);
    end
    for (int f = 0; f < 2; f++) begin
      cfg(2'(f), 3'h0, 2'h1);
      repeat (6) begin
        wait_rise();
        chk_pin(o_mod_bit, host_bit);
      end
    end
    cfg(2'h0, 3'h0, 2'h0);
    chk_pin(o_data_io_oe_n, 1'h0);
    cfg(2'h1, 3'h1, 2'h0);
    chk_pin(o_data_io_oe_n, 1'h1);
    i_pll_lock <= 1'h0;
    cfg(2'h0, 3'h4, 2'h0);
    toggles(t);
    chk_word(32'(t), 32'h0);
    i_pll_lock <= 1'h1;
    toggles(t);
    chk_word(32'(t >= 3), 32'h1);
    cfg(2'h0, 3'h0, 2'h0);
    // Sync receive: one demodulator edge locks, host captures on rise
    i_demod_bit <= !i_demod_bit;
    repeat (60) @(posedge i_clk);
    chk_pin(host_rx, i_demod_bit);
    for (int i = 0; i < 8; i++) begin
      c = {2'(i % 4), 3'(i), 3'($urandom % 2)};
      bus(1'h1, i[0] ? `RDP_OFS_CLK_B : `RDP_OFS_CLK_A, {24'h0, c});
      bus(1'h1, i[0] ? `RDP_OFS_CLK_A : `RDP_OFS_CLK_B, 32'h3F);
      bus(1'h1, `RDP_OFS_MAIN, {30'h0, i[0], 1'h0});
      wait_rise();
      wait_rise();
      n = 0;
      while (o_data_clock === 1'h1) begin
        @(posedge i_clk);
        n++;
      end
      chk_word(32'(n), 32'(2 * (int'(c[2:0]) + 1) * d1x2[i] * (1 << c[7:6])));
    end
    stop_test();
  end
endmodule // testbench
